// ### verilog/cap_pkg.sv
package cap_pkg;

    // ======================================
    // memory geometry
    localparam int             CHANNELS   = 16;
    localparam int             GROUPS     = 4;
    localparam int             GROUP_W    = 4;
    localparam int             DEPTH      = 256;
    localparam int             ADDR_W     = 8;
    localparam int             FIFO_DEPTH = 4;
    localparam logic [8:0]     FULL_COUNT = 9'h100;

    // ======================================
    // divide ratios minus one, per format
    localparam logic [1:0]     DIV_4CH    = 2'h3;
    localparam logic [1:0]     DIV_8CH    = 2'h1;
    localparam logic [1:0]     DIV_16CH   = 2'h0;

    // ======================================
    // trigger counter figures
    localparam logic [7:0]     POST_PRE    = 8'h10;
    localparam logic [7:0]     POST_CENTER = 8'h80;
    localparam logic [7:0]     POST_POST   = 8'hf0;
    localparam logic [7:0]     LINE_LAST   = 8'hff;
    localparam logic [3:0]     LAST_CHAN   = 4'hf;

    // ======================================
    // display clock timing
    localparam int             CLK_PERIOD_NS  = 8;
    localparam int             DISP_PERIOD_NS = 2000;
    localparam int             DISP_CYCLES    = DISP_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0]     DISP_CYC_M1    = 8'(DISP_CYCLES - 1);

    // ======================================
    // modes and carriers
    typedef enum logic [1:0] {fmt_4ch, fmt_8ch, fmt_16ch} format_e;
    typedef enum logic [1:0] {pos_pre, pos_center, pos_post} position_e;

    typedef struct packed {
        logic       data;
        logic       blank;
        logic       intensify;
        logic       line_start;
        logic [3:0] channel;
    } disp_bit_s;

    typedef struct packed {
        logic display_mode;
        logic flag;
        logic frame;
        logic sweep_reset;
        logic master_reset;
    } status_s;

endpackage

// ### verilog/capture_ram.sv
`timescale 1ns/10ps
module capture_ram (
    // clock
    input  wire logic                       clock_i,
    // write side
    input  wire logic                       wr_en_i,
    input  wire logic [cap_pkg::ADDR_W-1:0] wr_addr_i,
    input  wire logic [cap_pkg::CHANNELS-1:0] wr_data_i,
    // read side
    input  wire logic [cap_pkg::ADDR_W-1:0] rd_addr_i,
    output logic      [cap_pkg::CHANNELS-1:0] rd_data_o
);

    // ======================================
    // sixteen 256-bit rams side by side
    logic [cap_pkg::CHANNELS-1:0] mem_q [cap_pkg::DEPTH];

    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_addr_i];
    end

endmodule

// ### verilog/stream_fifo.sv
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wr_q, wr_d;
    logic [PW:0]      rd_q, rd_d;
    logic             push, pop;

    assign in_ready_o  = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o  = mem_q[rd_q[PW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        if (!reset_n_i) begin
            wr_d = '0;
            rd_d = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        wr_q <= wr_d;
        rd_q <= rd_d;
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data_i;
        end
    end

    full_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !in_ready_o && !out_ready_i |=> !in_ready_o)
        else $error("fifo left full without a pop");

endmodule

// ### verilog/capture_display.sv
`timescale 1ns/10ps
// Summary of operation
// - sixteen 256-bit rams, 4/8/16 channel formats
// - four groups of four channels, one section each
// - four-channel: shift four samples of first channel
// - eight/sixteen: latch two-by-two or four-by-one samples
// - data latch feeds the group's four rams
// - ram outputs combined per format on readout
// - display end resets trigger, counters, mode
// - latch at fast clock, write at memory clock
// - memory clock is fast clock divided 1/2/4
// - record until trigger plus post-trigger portion
// - trigger flop enables separately divided trigger clock
// - trigger counter counts 16/128/240, raises first flag
// - first flag gated with memory clock enters display
// - 2 us display clock replaces store clock
// - sixteen ram outputs read out serially
// - 256 counts per line, second flag advances channel
// - sixteen lines end display, reset, restart store
// - full-fill holds trigger until address wraps once
// - first-trigger blanks never-written locations
// - parallel, serial data and status outputs
module capture_display (
    // clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         reset_n_i,
    // probe side pins
    input  wire logic [cap_pkg::CHANNELS-1:0] probe_i,
    input  wire logic                         trigger_i,
    // sample interval enable pulse
    input  wire logic                         sample_tick_i,
    // settings
    input  wire cap_pkg::format_e             format_i,
    input  wire cap_pkg::position_e           position_i,
    input  wire logic                         full_fill_i,
    input  wire logic                         ext_disp_sel_i,
    // connector inputs
    input  wire logic                         record_enable_i,
    input  wire logic                         ext_disp_clk_i,
    // serial readout
    output cap_pkg::disp_bit_s                serial_o,
    output logic                              serial_valid_o,
    input  wire logic                         serial_ready_i,
    // parallel readout and status
    output logic      [cap_pkg::CHANNELS-1:0] parallel_o,
    output cap_pkg::status_s                  status_o
);

    typedef enum logic {st_store, st_display} mode_e;

    // ======================================
    // pin synchronisers
    logic [cap_pkg::CHANNELS-1:0] probe_m_q, probe_q;
    logic [2:0]                   pin_m_q, pin_q;
    logic                         xclk_prev_q;
    logic                         trig_s, rec_s, xclk_s;

    always_ff @(posedge clock_i) begin
        probe_m_q   <= probe_i;
        probe_q     <= probe_m_q;
        pin_m_q     <= {ext_disp_clk_i, record_enable_i, trigger_i};
        pin_q       <= pin_m_q;
        xclk_prev_q <= pin_q[2];
    end

    assign trig_s = pin_q[0];
    assign rec_s  = pin_q[1];
    assign xclk_s = pin_q[2];

    // ======================================
    // sequencer state
    mode_e                        mode_q, mode_d;
    logic                         trig_ff_q, trig_ff_d;
    logic                         first_flag_q, first_flag_d;
    logic [7:0]                   trig_cnt_q, trig_cnt_d;
    logic [3:0]                   chan_q, chan_d;
    logic [cap_pkg::ADDR_W-1:0]   addr_q, addr_d;
    logic [cap_pkg::ADDR_W-1:0]   base_q, base_d;
    logic [cap_pkg::ADDR_W-1:0]   rd_addr_q, rd_addr_d;
    logic [cap_pkg::ADDR_W-1:0]   trig_addr_q, trig_addr_d;
    logic [8:0]                   written_q, written_d;
    logic [1:0]                   mem_div_q, mem_div_d;
    logic [1:0]                   trig_div_q, trig_div_d;
    logic [7:0]                   disp_div_q, disp_div_d;
    logic                         wr_q, wr_d;
    logic [cap_pkg::CHANNELS-1:0] steer_q, steer_d;
    logic [cap_pkg::CHANNELS-1:0] latch_q, latch_d;
    logic                         pend_q, pend_d;
    logic [1:0]                   pend_sub_q, pend_sub_d;
    cap_pkg::disp_bit_s           pend_meta_q, pend_meta_d;
    logic                         mreset_q, mreset_d;
    logic                         sweep_q, sweep_d;
    logic [cap_pkg::CHANNELS-1:0] par_q, par_d;

    // ======================================
    // clock enables
    logic [1:0]                   ratio_m1;
    logic [7:0]                   post_cnt;
    logic                         disp_raw, disp_tick, hf_tick, mem_tick;
    logic                         trig_run, trig_tick, fifo_ready, full;
    logic [cap_pkg::CHANNELS-1:0] steer_next, rd_data;
    logic [8:0]                   valid_sum;
    cap_pkg::disp_bit_s           push_data;

    always_comb begin
        unique case (format_i)
            cap_pkg::fmt_4ch:  ratio_m1 = cap_pkg::DIV_4CH;
            cap_pkg::fmt_8ch:  ratio_m1 = cap_pkg::DIV_8CH;
            cap_pkg::fmt_16ch: ratio_m1 = cap_pkg::DIV_16CH;
            default:           ratio_m1 = cap_pkg::DIV_16CH;
        endcase
        unique case (position_i)
            cap_pkg::pos_pre:    post_cnt = cap_pkg::POST_PRE;
            cap_pkg::pos_center: post_cnt = cap_pkg::POST_CENTER;
            cap_pkg::pos_post:   post_cnt = cap_pkg::POST_POST;
            default:             post_cnt = cap_pkg::POST_CENTER;
        endcase
    end

    assign full      = written_q == cap_pkg::FULL_COUNT;
    assign disp_raw  = ext_disp_sel_i ? (xclk_s && !xclk_prev_q)
                                      : (disp_div_q == cap_pkg::DISP_CYC_M1);
    assign disp_tick = disp_raw && fifo_ready && !pend_q;
    // display clock stands in for the store clock
    assign hf_tick   = (mode_q == st_display) ? disp_tick : (sample_tick_i && rec_s);
    assign mem_tick  = hf_tick && (mem_div_q == ratio_m1);
    assign trig_run  = trig_ff_q || (mode_q == st_display);
    assign trig_tick = hf_tick && trig_run && (trig_div_q == ratio_m1);

    // ======================================
    // input steering, one stage per group
    for (genvar g = 0; g < cap_pkg::GROUPS; g++) begin : g_steer
        localparam int B = g * cap_pkg::GROUP_W;
        always_comb begin
            unique case (format_i)
                cap_pkg::fmt_4ch:
                    steer_next[B+3:B] = {steer_q[B+2:B], probe_q[B]};
                cap_pkg::fmt_8ch:
                    steer_next[B+3:B] = {steer_q[B+1:B], probe_q[B+1], probe_q[B]};
                default:
                    steer_next[B+3:B] = probe_q[B+3:B];
            endcase
        end
    end

    // ======================================
    // output steering: bit of the word for a channel and sub-sample
    function automatic logic [3:0] sel_bit(input cap_pkg::format_e fmt, input logic [3:0] ch,
                                           input logic [1:0] sub);
        unique case (fmt)
            cap_pkg::fmt_4ch: sel_bit = {ch[1:0], ~sub};
            cap_pkg::fmt_8ch: sel_bit = {ch[2:1], ~sub[0], ch[0]};
            default:          sel_bit = ch;
        endcase
    endfunction

    assign valid_sum = {1'b0, rd_addr_q - base_q} + written_q;

    // ======================================
    // sequencer next state
    always_comb begin
        mode_d       = mode_q;
        trig_ff_d    = trig_ff_q;
        first_flag_d = first_flag_q;
        trig_cnt_d   = trig_cnt_q;
        chan_d       = chan_q;
        addr_d       = addr_q;
        base_d       = base_q;
        rd_addr_d    = rd_addr_q;
        trig_addr_d  = trig_addr_q;
        written_d    = written_q;
        mem_div_d    = mem_div_q;
        trig_div_d   = trig_div_q;
        steer_d      = steer_q;
        latch_d      = latch_q;
        pend_sub_d   = pend_sub_q;
        pend_meta_d  = pend_meta_q;
        par_d        = par_q;
        wr_d         = 1'b0;
        pend_d       = 1'b0;
        mreset_d     = 1'b0;
        sweep_d      = 1'b0;
        disp_div_d   = (disp_div_q == cap_pkg::DISP_CYC_M1) ? '0 : disp_div_q + 8'h01;

        if (hf_tick) begin
            mem_div_d = (mem_div_q == ratio_m1) ? '0 : mem_div_q + 2'h1;
            if (trig_run) begin
                trig_div_d = (trig_div_q == ratio_m1) ? '0 : trig_div_q + 2'h1;
            end
        end
        if (pend_q) begin
            par_d = rd_data;
        end

        if (mode_q == st_store) begin
            if (hf_tick) begin
                steer_d = steer_next;
            end
            if (mem_tick) begin
                latch_d = steer_next;
                wr_d    = 1'b1;
            end
            if (wr_q) begin
                addr_d    = addr_q + 8'h01;
                written_d = full ? written_q : written_q + 9'h001;
            end
            if (trig_s && !trig_ff_q && (!full_fill_i || full)) begin
                trig_ff_d   = 1'b1;
                trig_addr_d = addr_q;
                trig_div_d  = '0;
                trig_cnt_d  = '0;
            end else if (trig_tick && !first_flag_q) begin
                if (trig_cnt_q == post_cnt - 8'h01) begin
                    first_flag_d = 1'b1;
                end else begin
                    trig_cnt_d = trig_cnt_q + 8'h01;
                end
            end
            if (wr_q && first_flag_q) begin
                mode_d       = st_display;
                base_d       = addr_q + 8'h01;
                rd_addr_d    = addr_q + 8'h01;
                first_flag_d = 1'b0;
                trig_cnt_d   = '0;
                chan_d       = '0;
                mem_div_d    = '0;
                trig_div_d   = '0;
            end
        end else begin
            if (hf_tick) begin
                pend_d                 = 1'b1;
                pend_sub_d             = mem_div_q;
                pend_meta_d.data       = 1'b0;
                pend_meta_d.channel    = chan_q;
                pend_meta_d.line_start = (trig_cnt_q == '0) && (mem_div_q == '0);
                pend_meta_d.blank      = !full && !valid_sum[8];
                pend_meta_d.intensify  = rd_addr_q == trig_addr_q;
            end
            if (mem_tick) begin
                rd_addr_d = rd_addr_q + 8'h01;
            end
            if (trig_tick) begin
                trig_cnt_d = trig_cnt_q + 8'h01;
                if (trig_cnt_q == cap_pkg::LINE_LAST) begin
                    sweep_d = 1'b1;
                    chan_d  = chan_q + 4'h1;
                    if (chan_q == cap_pkg::LAST_CHAN) begin
                        mreset_d = 1'b1;
                    end
                end
            end
        end

        if (!reset_n_i || mreset_q) begin
            mode_d       = st_store;
            trig_ff_d    = 1'b0;
            first_flag_d = 1'b0;
            trig_cnt_d   = '0;
            chan_d       = '0;
            addr_d       = '0;
            base_d       = '0;
            rd_addr_d    = '0;
            trig_addr_d  = '0;
            written_d    = '0;
            mem_div_d    = '0;
            trig_div_d   = '0;
            steer_d      = '0;
            latch_d      = '0;
            wr_d         = 1'b0;
            pend_d       = 1'b0;
            pend_sub_d   = '0;
            pend_meta_d  = '0;
            sweep_d      = 1'b0;
        end
        if (!reset_n_i) begin
            disp_div_d = '0;
            par_d      = '0;
            mreset_d   = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        mode_q       <= mode_d;
        trig_ff_q    <= trig_ff_d;
        first_flag_q <= first_flag_d;
        trig_cnt_q   <= trig_cnt_d;
        chan_q       <= chan_d;
        addr_q       <= addr_d;
        base_q       <= base_d;
        rd_addr_q    <= rd_addr_d;
        trig_addr_q  <= trig_addr_d;
        written_q    <= written_d;
        mem_div_q    <= mem_div_d;
        trig_div_q   <= trig_div_d;
        disp_div_q   <= disp_div_d;
        wr_q         <= wr_d;
        steer_q      <= steer_d;
        latch_q      <= latch_d;
        pend_q       <= pend_d;
        pend_sub_q   <= pend_sub_d;
        pend_meta_q  <= pend_meta_d;
        mreset_q     <= mreset_d;
        sweep_q      <= sweep_d;
        par_q        <= par_d;
    end

    // ======================================
    // memory and readout buffer
    capture_ram u_ram (
        .clock_i   (clock_i),
        .wr_en_i   (wr_q && (mode_q == st_store)),
        .wr_addr_i (addr_q),
        .wr_data_i (latch_q),
        .rd_addr_i (rd_addr_q),
        .rd_data_o (rd_data)
    );

    always_comb begin
        push_data      = pend_meta_q;
        push_data.data = rd_data[sel_bit(format_i, pend_meta_q.channel, pend_sub_q)];
    end

    stream_fifo #(
        .WIDTH ($bits(cap_pkg::disp_bit_s)),
        .DEPTH (cap_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (pend_q),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_data),
        .out_valid_o (serial_valid_o),
        .out_ready_i (serial_ready_i),
        .out_data_o  (serial_o)
    );

    // ======================================
    // connector outputs
    assign parallel_o                = par_q;
    assign status_o.display_mode     = mode_q == st_display;
    assign status_o.flag             = first_flag_q || sweep_q;
    assign status_o.frame            = mreset_q;
    assign status_o.sweep_reset      = sweep_q;
    assign status_o.master_reset     = mreset_q;

    // ======================================
    // checks
    display_entry_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(mode_q == st_display) |-> $past(first_flag_q) && $past(wr_q))
        else $error("display entered without first flag and memory clock");

    frame_reset_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mreset_q |=> mode_q == st_store && !trig_ff_q && addr_q == '0 && trig_cnt_q == '0)
        else $error("master reset did not clear sequencer");

    line_flag_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        sweep_q |-> $past(trig_cnt_q) == cap_pkg::LINE_LAST && $past(trig_tick))
        else $error("line flag without 256 counts");

    chan_step_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        sweep_q && !mreset_q |-> chan_q == $past(chan_q) + 4'h1)
        else $error("channel did not advance on line flag");

    full_fill_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(trig_ff_q) && full_fill_i && $past(full_fill_i) |-> $past(full))
        else $error("trigger taken before memory filled");

    post_count_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(first_flag_q) && $stable(position_i) |-> $past(trig_cnt_q) == post_cnt - 8'h01)
        else $error("first flag at wrong post-trigger count");

    addr_step_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_q && mode_q == st_store && !mreset_q |=> addr_q == $past(addr_q) + 8'h01)
        else $error("address counter did not step on write");

    mem_clock_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        format_i == cap_pkg::fmt_16ch && mode_q == st_store && hf_tick
        && mem_div_q == '0 && !mreset_q |=> wr_q)
        else $error("sixteen-channel format not writing every sample");

endmodule

// ### testbench/probe_side_model.sv
`timescale 1ns/10ps
module probe_side_model (
    // clock
    input  wire logic clock_i,
    // far side lines
    output logic      record_enable_o,
    output logic      disp_clk_o,
    output logic      ready_o
);
    logic [1:0] phase_q = 2'h0;

    // ==========================================
    // record enable, display clock, readout drain
    initial begin
        record_enable_o = 1'b1;
        disp_clk_o = 1'b0;
        ready_o = 1'b0;
    end

    always @(negedge clock_i) begin
        phase_q <= phase_q + 2'h1;
        disp_clk_o <= phase_q[0];
        ready_o <= ($urandom_range(3) != 0);
    end
endmodule

// ### testbench/capture_display_bench.sv
`timescale 1ns/10ps
module capture_display_bench;
    logic               clock_i = 1'b0;
    logic               reset_n_i = 1'b0;
    logic [15:0]        probe_i = 16'h0;
    logic               trigger_i = 1'b0;
    logic               sample_tick_i = 1'b0;
    cap_pkg::format_e   format_i = cap_pkg::fmt_16ch;
    logic               record_enable_i;
    logic               ext_disp_clk_i;
    logic               serial_ready_i;
    logic               serial_valid_o;
    cap_pkg::disp_bit_s serial_o;
    logic [15:0]        parallel_o;
    cap_pkg::status_s   status_o;
    logic [4:0]         notes_q[$];
    logic [3:0]         r;
    int                 miscompares = 0;
    int                 num_checks = 0;
    int                 sweeps = 0;

    always #4 clock_i = ~clock_i;

    capture_display dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .probe_i(probe_i), .trigger_i(trigger_i),
        .sample_tick_i(sample_tick_i), .format_i(format_i), .position_i(cap_pkg::pos_pre),
        .full_fill_i(1'b1), .ext_disp_sel_i(1'b1), .record_enable_i(record_enable_i),
        .ext_disp_clk_i(ext_disp_clk_i), .serial_o(serial_o), .serial_valid_o(serial_valid_o),
        .serial_ready_i(serial_ready_i), .parallel_o(parallel_o), .status_o(status_o));

    probe_side_model model (.clock_i(clock_i), .record_enable_o(record_enable_i),
        .disp_clk_o(ext_disp_clk_i), .ready_o(serial_ready_i));

    // ==========================================
    // reporting
    task stop_test;
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task cmp(input string name, input logic [4:0] exp, input logic [4:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ==========================================
    // readout watcher
    always @(posedge clock_i) begin
        if (status_o.sweep_reset === 1'b1)
            sweeps++;
        if (serial_valid_o === 1'b1 && serial_ready_i === 1'b1) begin
            if (notes_q.size() == 0)
                cmp("serial_extra", 5'h0, 5'h1f);
            else
                cmp("serial_bit", notes_q.pop_front(), {serial_o.data, serial_o.channel});
        end
    end

    // ==========================================
    // one store and display frame
    task run_frame(input cap_pkg::format_e fmt, input int ratio, input logic [15:0] pat);
        int c;
        int j;
        format_i = fmt;
        probe_i = pat;
        sweeps = 0;
        for (c = 0; c < 16; c++)
            for (j = 0; j < 256 * ratio; j++)
                notes_q.push_back({(ratio == 4) ? pat[4 * (c % 4)] : pat[c], 4'(c)});
        sample_tick_i = 1'b1;
        repeat (300 * ratio) @(negedge clock_i);
        trigger_i = 1'b1;
        repeat (4) @(negedge clock_i);
        trigger_i = 1'b0;
        for (j = 0; j < 4000 && status_o.display_mode !== 1'b1; j++)
            @(negedge clock_i);
        cmp("display_mode", 5'h1, {4'h0, status_o.display_mode});
        sample_tick_i = 1'b0;
        for (j = 0; j < 60000 && status_o.master_reset !== 1'b1; j++)
            @(negedge clock_i);
        cmp("master_reset", 5'h1, {4'h0, status_o.master_reset});
        @(negedge clock_i);
        cmp("store_mode", 5'h0, {4'h0, status_o.display_mode});
        repeat (20) @(negedge clock_i);
        cmp("sweeps", 5'h10, 5'(sweeps));
        cmp("left_over", 5'h0, 5'(notes_q.size()));
        cmp("parallel", 5'h0, {4'h0, parallel_o !== pat});
    endtask

    initial begin
        repeat (95000) @(posedge clock_i);
        miscompares++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hf3d84034));
        repeat (2) @(negedge clock_i);
        reset_n_i = 1'b1;
        run_frame(cap_pkg::fmt_16ch, 1, 16'($urandom));
        r = 4'($urandom);
        run_frame(cap_pkg::fmt_4ch, 4, {{4{r[3]}}, {4{r[2]}}, {4{r[1]}}, {4{r[0]}}});
        stop_test();
    end
endmodule
